/* File: rtl/cslc_chan.sv */
// one channel: enable register and four source bits
`timescale 1ns/1ns
`default_nettype none
module cslc_chan
   import cslc_pkg::*;
(
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               resetn_i,
   input  wire logic               ce_i,
   // source levels, bit order as the status register
   input  wire logic [NUM_SRC-1:0] src_i,
   // register access
   input  wire logic               en_we_i,
   input  wire logic [NUM_SRC-1:0] en_wdata_i,
   input  wire logic [NUM_SRC-1:0] clr_i,
   // state
   output logic      [NUM_SRC-1:0] en_o,
   output logic      [NUM_SRC-1:0] stat_o,
   output logic      [NUM_SRC-1:0] alarm_o,
   output logic      [NUM_SRC-1:0] set_o,
   output logic                    irq_o
);

   typedef struct packed {
      logic [NUM_SRC-1:0] en;
   } cslc_chan_s;

   cslc_chan_s q;
   cslc_chan_s d;

   always_comb
   begin
      d = q;
      if (en_we_i)
      begin
         d.en = en_wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         q.en <= ENA_RST;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   for (genvar s = 0; s < NUM_SRC; s++)
   begin : g_src
      cslc_src_bit u_src (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .ce_i     (ce_i),
         .level_i  (src_i[s]),
         .enable_i (q.en[s]),
         .clear_i  (clr_i[s]),
         .sticky_o (stat_o[s]),
         .level_o  (alarm_o[s]),
         .set_o    (set_o[s])
      );
   end

   assign en_o  = q.en;
   assign irq_o = |(stat_o & q.en);

endmodule // cslc_chan
`default_nettype wire

/* File: rtl/cslc_pkg.sv */
// constants and types shared by the channel source interrupt logic
package cslc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int NUM_CHAN = 3;
   localparam int NUM_SRC  = 4;
   localparam int IDX_W    = 7;

   ////////////////////////////////////////////////////////////////////////////
   // source bit positions, shared by enable, status and alarm registers
   localparam int SRC_DRIVE_MON = 0;
   localparam int SRC_SIG_LOSS  = 1;
   localparam int SRC_LOCK_LOSS = 2;
   localparam int SRC_FIFO_LIM  = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [NUM_CHAN-1:0][IDX_W-1:0] ENA_IDX   = {7'h11, 7'h09, 7'h01};
   localparam logic [NUM_CHAN-1:0][IDX_W-1:0] STAT_IDX  = {7'h12, 7'h0a, 7'h02};
   localparam logic [NUM_CHAN-1:0][IDX_W-1:0] ALARM_IDX = {7'h13, 7'h0b, 7'h03};
   localparam logic [IDX_W-1:0]               BLK_STAT_IDX = 7'h28;
   localparam logic [IDX_W-1:0]               BLK_MASK_IDX = 7'h29;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [NUM_SRC-1:0]  ENA_RST      = 4'h0;
   localparam logic [NUM_SRC-1:0]  STAT_RST     = 4'h0;
   localparam logic [NUM_CHAN-1:0] BLK_STAT_RST = 3'h0;
   localparam logic [NUM_CHAN-1:0] BLK_MASK_RST = 3'h0;
   localparam logic                WAIT_RST     = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave states
   typedef enum logic [1:0] {
      CSLC_IDLE = 2'b01,
      CSLC_ACK  = 2'b10
   } cslc_bus_e;

endpackage

/* File: rtl/cslc_src_bit.sv */
// one interrupt source: level tracker and clear-on-read sticky change bit
`timescale 1ns/1ns
`default_nettype none
module cslc_src_bit
   import cslc_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic ce_i,
   // source and control
   input  wire logic level_i,
   input  wire logic enable_i,
   input  wire logic clear_i,
   // state
   output logic      sticky_o,
   output logic      level_o,
   output logic      set_o
);

   typedef struct packed {
      logic level;
      logic sticky;
   } cslc_src_s;

   cslc_src_s q;
   cslc_src_s d;

   always_comb
   begin
      d = q;
      // either edge of the level counts as a change
      set_o    = enable_i & (level_i ^ q.level); // RULE1 RULE2 RULE10
      d.level  = level_i;
      // set wins over a clear in the same cycle
      d.sticky = set_o | (q.sticky & ~clear_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         q <= '0;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   assign sticky_o = q.sticky;
   assign level_o  = q.level;

endmodule // cslc_src_bit
`default_nettype wire

/* File: rtl/cslc_top.sv */
// channel source interrupts: three channels behind an avalon-mm slave
//
// Behaviour
// (RULE1) enabled signal-loss bit: set status on each declare or clear of signal loss
// (RULE2) enabled drive-monitor bit: set status on each rise and fall of the monitor
// (RULE3) enable bits are read/write and reset to zero
// (RULE4) status layout: fifo 3, lock 2, signal 1, drive 0; bits 7-4 read zero
// (RULE5) status bit shows change since last read; the read clears it; resets zero
// (RULE6) fifo-limit status records change only; present level is alarm bit 3
// (RULE7) lock-loss change sets status bit 2; present level is alarm bit 2
// (RULE8) status registers sit at 0x02, 0x0a and 0x12 for channels 0 to 2
// (RULE9) signal and drive status clear on read; levels at alarm bits 1 and 0
// (RULE10) enable bits 3 and 2 gate fifo and lock changes, both directions
// (RULE11) a change during the status read keeps its bit set
// (RULE12) channel request high while any enabled status bit is set
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cslc_top
   import cslc_pkg::*;
(
   // clock, reset, enable
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   input  wire logic                ce_i,
   // avalon-mm slave
   input  wire logic [8:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   // condition levels per channel
   input  wire logic [NUM_CHAN-1:0] signal_loss_i,
   input  wire logic [NUM_CHAN-1:0] lock_loss_i,
   input  wire logic [NUM_CHAN-1:0] fifo_limit_alarm_i,
   input  wire logic [NUM_CHAN-1:0] drive_monitor_output_i,
   // interrupts
   output logic      [NUM_CHAN-1:0] chan_irq_o,
   output logic                     irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      cslc_bus_e           st;
      logic                wait_req;
      logic [31:0]         rdata;
      logic [NUM_CHAN-1:0] blk_stat;
      logic [NUM_CHAN-1:0] blk_mask;
      logic [NUM_CHAN-1:0] chan_irq;
      logic                irq;
   } cslc_top_s;

   cslc_top_s q;
   cslc_top_s d;

   logic [IDX_W-1:0]               idx;
   logic                           req;
   logic                           acc;
   logic [NUM_CHAN-1:0]            en_we;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] clr;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] src;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] en;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] stat;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] alarm;
   logic [NUM_CHAN-1:0][NUM_SRC-1:0] set;
   logic [NUM_CHAN-1:0]            ch_irq;

   assign idx = avs_address_i[8:2];
   assign req = avs_read_i | avs_write_i;
   assign acc = req & (q.st == CSLC_ACK);

   ////////////////////////////////////////////////////////////////////////////
   // channels

   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : g_chan
      assign src[c][SRC_DRIVE_MON] = drive_monitor_output_i[c]; // RULE2
      assign src[c][SRC_SIG_LOSS]  = signal_loss_i[c]; // RULE1
      assign src[c][SRC_LOCK_LOSS] = lock_loss_i[c]; // RULE7 RULE10
      assign src[c][SRC_FIFO_LIM]  = fifo_limit_alarm_i[c]; // RULE6 RULE10

      cslc_chan u_chan (
         .clk_i      (clk_i),
         .resetn_i   (resetn_i),
         .ce_i       (ce_i),
         .src_i      (src[c]),
         .en_we_i    (en_we[c]),
         .en_wdata_i (avs_writedata_i[NUM_SRC-1:0]),
         .clr_i      (clr[c]),
         .en_o       (en[c]),
         .stat_o     (stat[c]),
         .alarm_o    (alarm[c]),
         .set_o      (set[c]),
         .irq_o      (ch_irq[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave, read mux, block interrupt

   always_comb
   begin
      logic [31:0] rd;
      logic        wr_ok;
      rd    = '0;
      wr_ok = avs_write_i & avs_byteenable_i[0];
      d     = q;
      en_we = '0;
      clr   = '0;
      // unmapped indices read zero; narrow fields sit low, upper bits zero
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         if (idx == ENA_IDX[c])
         begin
            rd[NUM_SRC-1:0] = en[c]; // RULE3
         end
         else if (idx == STAT_IDX[c])
         begin
            rd[NUM_SRC-1:0] = stat[c]; // RULE4 RULE8
         end
         else if (idx == ALARM_IDX[c])
         begin
            rd[NUM_SRC-1:0] = alarm[c]; // RULE6 RULE7 RULE9
         end
      end
      if (idx == BLK_STAT_IDX)
      begin
         rd[NUM_CHAN-1:0] = q.blk_stat;
      end
      else if (idx == BLK_MASK_IDX)
      begin
         rd[NUM_CHAN-1:0] = q.blk_mask;
      end

      case (q.st)
         CSLC_IDLE:
         begin
            if (req)
            begin
               d.st       = CSLC_ACK;
               d.wait_req = 1'b0;
               d.rdata    = avs_read_i ? rd : 32'h0000_0000;
            end
         end
         CSLC_ACK:
         begin
            d.st       = CSLC_IDLE;
            d.wait_req = 1'b1;
         end
         default:
         begin
            d.st       = CSLC_IDLE;
            d.wait_req = WAIT_RST;
         end
      endcase

      // side effects only at the accepting edge
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         if (acc && wr_ok && idx == ENA_IDX[c])
         begin
            en_we[c] = 1'b1; // RULE3
         end
         // clear only bits that were handed out; later events survive
         if (acc && avs_read_i && idx == STAT_IDX[c])
         begin
            clr[c] = q.rdata[NUM_SRC-1:0]; // RULE5 RULE9 RULE11
         end
      end

      if (acc && wr_ok && idx == BLK_MASK_IDX)
      begin
         d.blk_mask = avs_writedata_i[NUM_CHAN-1:0];
      end
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         // write one clears, a new event in the same cycle wins
         if (acc && wr_ok && idx == BLK_STAT_IDX && avs_writedata_i[c])
         begin
            d.blk_stat[c] = 1'b0;
         end
         if (|set[c])
         begin
            d.blk_stat[c] = 1'b1;
         end
      end

      d.chan_irq = ch_irq; // RULE12
      d.irq      = |(d.blk_stat & d.blk_mask);
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         q.st       <= CSLC_IDLE;
         q.wait_req <= WAIT_RST;
         q.rdata    <= 32'h0000_0000;
         q.blk_stat <= BLK_STAT_RST;
         q.blk_mask <= BLK_MASK_RST;
         q.chan_irq <= '0;
         q.irq      <= 1'b0;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   assign avs_readdata_o    = q.rdata;
   assign avs_waitrequest_o = q.wait_req;
   assign chan_irq_o        = q.chan_irq;
   assign irq_o             = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   upper_bits_zero_a: assert property ( // RULE4
      avs_readdata_o[31:NUM_SRC] == '0)
      else $error("read data above bit 3 not zero");

   // bus handshake: answer after one cycle, never a longer wait than that
   wait_answer_a: assert property ( // RULE8
      ce_i && req && q.st == CSLC_IDLE
      |=> !avs_waitrequest_o)
      else $error("request not answered after one cycle");

   wait_pulse_a: assert property ( // RULE8
      ce_i && !avs_waitrequest_o
      |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   // read data stands until the next capture, so a slow master still sees it
   rdata_hold_a: assert property ( // RULE5
      !(ce_i && req && q.st == CSLC_IDLE)
      |=> $stable(avs_readdata_o))
      else $error("read data changed without a request");

   write_rdata_a: assert property ( // RULE8
      ce_i && avs_write_i && !avs_read_i && q.st == CSLC_IDLE
      |=> avs_readdata_o == '0)
      else $error("read data not zero after a write");

   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : g_chk
      sig_loss_set_a: assert property ( // RULE1
         ce_i && en[c][SRC_SIG_LOSS] && (signal_loss_i[c] != alarm[c][SRC_SIG_LOSS])
         |=> stat[c][SRC_SIG_LOSS])
         else $error("signal loss change did not set status");

      drive_mon_set_a: assert property ( // RULE2
         ce_i && en[c][SRC_DRIVE_MON]
         && (drive_monitor_output_i[c] != alarm[c][SRC_DRIVE_MON])
         |=> stat[c][SRC_DRIVE_MON])
         else $error("drive monitor change did not set status");

      disabled_quiet_a: assert property ( // RULE3
         ce_i && !en[c][SRC_SIG_LOSS] && !stat[c][SRC_SIG_LOSS]
         |=> !stat[c][SRC_SIG_LOSS])
         else $error("disabled source set its status");

      read_clears_a: assert property ( // RULE5
         ce_i && acc && avs_read_i && idx == STAT_IDX[c] && set[c] == '0
         |=> (stat[c] & $past(avs_readdata_o[NUM_SRC-1:0])) == '0)
         else $error("status read did not clear bits");

      read_keeps_a: assert property ( // RULE11
         ce_i && acc && avs_read_i && idx == STAT_IDX[c] && set[c] != '0
         |=> (stat[c] & $past(set[c])) == $past(set[c]))
         else $error("event during read was lost");

      fifo_level_a: assert property ( // RULE6
         ce_i |=> alarm[c][SRC_FIFO_LIM] == $past(fifo_limit_alarm_i[c]))
         else $error("fifo limit level not shown");

      lock_set_a: assert property ( // RULE7
         ce_i && en[c][SRC_LOCK_LOSS] && $changed(lock_loss_i[c])
         && (lock_loss_i[c] != alarm[c][SRC_LOCK_LOSS])
         |=> stat[c][SRC_LOCK_LOSS] ##0 alarm[c][SRC_LOCK_LOSS] == $past(lock_loss_i[c]))
         else $error("lock loss change not recorded");

      stat_map_a: assert property ( // RULE8
         avs_read_i && !avs_waitrequest_o && idx == STAT_IDX[c]
         |-> avs_readdata_o[NUM_SRC-1:0] == $past(stat[c]))
         else $error("status register read wrong channel");

      low_levels_a: assert property ( // RULE9
         ce_i |=> alarm[c][1:0]
         == $past({signal_loss_i[c], drive_monitor_output_i[c]}))
         else $error("signal or drive level not shown");

      fifo_gate_a: assert property ( // RULE10
         ce_i && en[c][SRC_FIFO_LIM]
         && (fifo_limit_alarm_i[c] != alarm[c][SRC_FIFO_LIM])
         |=> stat[c][SRC_FIFO_LIM])
         else $error("fifo limit change did not set status");

      chan_irq_a: assert property ( // RULE12
         ce_i |=> chan_irq_o[c] == $past(|(stat[c] & en[c])))
         else $error("channel request does not follow status");

      lock_gate_a: assert property ( // RULE10
         ce_i && en[c][SRC_LOCK_LOSS]
         && (lock_loss_i[c] != alarm[c][SRC_LOCK_LOSS])
         |=> stat[c][SRC_LOCK_LOSS])
         else $error("lock loss change did not set status");

      drive_quiet_a: assert property ( // RULE2
         ce_i && !en[c][SRC_DRIVE_MON] && !stat[c][SRC_DRIVE_MON]
         |=> !stat[c][SRC_DRIVE_MON])
         else $error("disabled drive monitor set its status");

      fifo_quiet_a: assert property ( // RULE10
         ce_i && !en[c][SRC_FIFO_LIM] && !stat[c][SRC_FIFO_LIM]
         |=> !stat[c][SRC_FIFO_LIM])
         else $error("disabled fifo limit set its status");

      all_quiet_a: assert property ( // RULE3
         ce_i && en[c] == '0 && stat[c] == '0
         |=> stat[c] == '0)
         else $error("disabled channel recorded a change");

      // only an accepted status read may take a bit away
      sticky_hold_a: assert property ( // RULE5
         ce_i && !(acc && avs_read_i && idx == STAT_IDX[c])
         |=> (stat[c] & $past(stat[c])) == $past(stat[c]))
         else $error("status bit cleared without a read");

      en_write_a: assert property ( // RULE3
         ce_i && acc && avs_write_i && avs_byteenable_i[0] && idx == ENA_IDX[c]
         |=> en[c] == $past(avs_writedata_i[NUM_SRC-1:0]))
         else $error("enable write did not land");

      en_hold_a: assert property ( // RULE3
         !(ce_i && acc && avs_write_i && idx == ENA_IDX[c])
         |=> $stable(en[c]))
         else $error("enable bits changed without a write");

      blk_set_a: assert property ( // RULE12
         ce_i && set[c] != '0
         |=> q.blk_stat[c])
         else $error("channel change did not reach block status");

      // write one clears only when no new change arrives in the same cycle
      blk_clear_a: assert property ( // RULE12
         ce_i && acc && avs_write_i && avs_byteenable_i[0] && idx == BLK_STAT_IDX
         && avs_writedata_i[c] && set[c] == '0
         |=> !q.blk_stat[c])
         else $error("block status bit not cleared by write");
   end

endmodule // cslc_top
`default_nettype wire

/* File: tb/tb_cslc_top.sv */
// self-checking bench for the channel source interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_cslc_top
   import cslc_pkg::*;
();

   ////////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   localparam int  LIMIT = 20000;
   logic           clk_i = 1'b0;
   logic           resetn_i = 1'b0;
   logic           ce_i = 1'b1;
   logic [8:0]     avs_address_i = 9'h000;
   logic           avs_read_i = 1'b0;
   logic           avs_write_i = 1'b0;
   logic [31:0]    avs_writedata_i = 32'h0;
   logic [3:0]     avs_byteenable_i = 4'hf;
   logic [31:0]    avs_readdata_o;
   logic           avs_waitrequest_o;
   logic [3:0]     lvl [3] = '{4'h0, 4'h0, 4'h0};
   logic [2:0]     chan_irq_o;
   logic           irq_o;
   int             fail_count = 0;
   int             checks = 0;
   int             cyc = 0;

   typedef struct {int c; int s; logic en; logic [31:0] stat;} cslc_row_s;
   // rows on one source alternate direction, so repeated rows test both edges
   cslc_row_s rows [13] = '{
      '{0, 0, 1'b1, 32'h01}, '{0, 1, 1'b1, 32'h02}, '{0, 2, 1'b1, 32'h04},
      '{0, 3, 1'b1, 32'h08}, '{1, 0, 1'b1, 32'h01}, '{1, 0, 1'b1, 32'h01},
      '{1, 1, 1'b0, 32'h00}, '{1, 2, 1'b1, 32'h04}, '{2, 3, 1'b1, 32'h08},
      '{2, 1, 1'b1, 32'h02}, '{2, 2, 1'b0, 32'h00}, '{2, 0, 1'b1, 32'h01},
      '{0, 1, 1'b1, 32'h02}};

   always #5 clk_i = ~clk_i;

   cslc_top dut (
      .clk_i                  (clk_i),
      .resetn_i               (resetn_i),
      .ce_i                   (ce_i),
      .avs_address_i          (avs_address_i),
      .avs_read_i             (avs_read_i),
      .avs_write_i            (avs_write_i),
      .avs_writedata_i        (avs_writedata_i),
      .avs_byteenable_i       (avs_byteenable_i),
      .avs_readdata_o         (avs_readdata_o),
      .avs_waitrequest_o      (avs_waitrequest_o),
      .signal_loss_i          ({lvl[2][1], lvl[1][1], lvl[0][1]}),
      .lock_loss_i            ({lvl[2][2], lvl[1][2], lvl[0][2]}),
      .fifo_limit_alarm_i     ({lvl[2][3], lvl[1][3], lvl[0][3]}),
      .drive_monitor_output_i ({lvl[2][0], lvl[1][0], lvl[0][0]}),
      .chan_irq_o             (chan_irq_o),
      .irq_o                  (irq_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checking and reporting
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t data got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_irq(input logic [3:0] exp);
      checks++;
      if ({irq_o, chan_irq_o} !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t irq got %h exp %h", $time, {irq_o, chan_irq_o}, exp);
      end
   endtask

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         fail_count++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus and source drivers
   function automatic logic [8:0] ba(input logic [6:0] idx);
      return {idx, 2'b00};
   endfunction

   task automatic flip(input int c, input int s);
      lvl[c][s] <= ~lvl[c][s];
   endtask

   // optional source flip at the taking edge lands with the clear-on-read
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd,
                      input int tc, input int ts);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do
      begin
         @(posedge clk_i);
         if (n == 0 && tc >= 0)
            flip(tc, ts);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      cmp_data(n, 32'h2);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      logic [31:0] x;
      bus(1'b1, a, d, be, x, -1, 0);
   endtask

   task automatic rdc(input logic [8:0] a, input logic [31:0] exp, input int tc = -1,
                      input int ts = 0);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, 4'hf, x, tc, ts);
      cmp_data(x, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      cslc_row_s r;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      foreach (rows[i])
      begin
         r = rows[i];
         wr(ba(ENA_IDX[r.c]), r.en ? (32'h1 << r.s) : 32'h0);
         flip(r.c, r.s);
         repeat (3) @(posedge clk_i);
         cmp_irq({1'b0, 3'(r.en) << r.c});
         rdc(ba(ALARM_IDX[r.c]), {28'h0, lvl[r.c]});
         rdc(ba(STAT_IDX[r.c]), r.stat);
         rdc(ba(STAT_IDX[r.c]), 32'h0);
         cmp_irq(4'h0);
      end
      $display("test row table done");
      // enable register width, byte enable and unmapped place
      wr(ba(ENA_IDX[0]), 32'hffffffff);
      rdc(ba(ENA_IDX[0]), 32'h0f);
      wr(ba(ENA_IDX[0]), 32'h0, 4'he);
      rdc(ba(ENA_IDX[0]), 32'h0f);
      rdc(9'h1fc, 32'h0);
      $display("test enable access done");
      // gating, block mask, clear and a change during the read
      flip(0, 2);
      repeat (3) @(posedge clk_i);
      cmp_irq(4'h1);
      wr(ba(ENA_IDX[0]), 32'h0);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h0);
      wr(ba(ENA_IDX[0]), 32'h0f);
      wr(ba(BLK_MASK_IDX), 32'h7);
      rdc(ba(BLK_MASK_IDX), 32'h7);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h9);
      rdc(ba(BLK_STAT_IDX), 32'h7);
      wr(ba(BLK_STAT_IDX), 32'h7);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h1);
      rdc(ba(STAT_IDX[0]), 32'h04, 0, 3);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h9);
      rdc(ba(STAT_IDX[0]), 32'h08);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h8);
      wr(ba(BLK_STAT_IDX), 32'h1);
      repeat (2) @(posedge clk_i);
      cmp_irq(4'h0);
      $display("test interrupt path done");
      // clock enable low freezes the change detector; the change lands after it
      ce_i <= 1'b0;
      flip(0, 1);
      repeat (4) @(posedge clk_i);
      cmp_irq(4'h0);
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cmp_irq(4'h9);
      rdc(ba(STAT_IDX[0]), 32'h02);
      $display("test clock enable done");
      // second reset in mid-run; disabled sources stay unrecorded
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      cmp_data({31'h0, avs_waitrequest_o}, 32'h1);
      cmp_irq(4'h0);
      for (int c = 0; c < NUM_CHAN; c++)
      begin
         rdc(ba(ENA_IDX[c]), 32'h0);
         rdc(ba(STAT_IDX[c]), 32'h0);
         rdc(ba(ALARM_IDX[c]), {28'h0, lvl[c]});
      end
      cmp_irq(4'h0);
      $display("test reset done");
      stop_test();
   end

endmodule // tb_cslc_top
`default_nettype wire
